// ==== shared/synth_pkg.sv ====
/*
  Constants for the synthesiser divider and clock control block and for
  the host controller that programs it over the 8-bit register port.
  Assumes both ends run on the one reference clock.
*/
package synth_pkg;
  // Register port offsets
  localparam logic [7:0] MAIN_REF_LO   = 8'h20;
  localparam logic [7:0] MAIN_REF_HI   = 8'h21;
  localparam logic [7:0] MAIN_FB_LO    = 8'h22;
  localparam logic [7:0] MAIN_FB_MID   = 8'h23;
  localparam logic [7:0] MAIN_FB_TOP   = 8'h24;
  localparam logic [7:0] AUX_REF_LO    = 8'h25;
  localparam logic [7:0] AUX_REF_HI    = 8'h26;
  localparam logic [7:0] AUX_FB_LO     = 8'h27;
  localparam logic [7:0] AUX_FB_HI     = 8'h28;
  localparam logic [7:0] BIT_RATE_CTRL = 8'h29;
  localparam logic [7:0] LOCK_STATUS   = 8'h2a;
  localparam logic [7:0] LOCK_IRQ_EN   = 8'h2b;
  // Field positions in the high bytes
  localparam int ENABLE_BIT      = 7;
  localparam int TX_LO_HALF_BIT  = 6;
  localparam int MIX_FILTER_BIT  = 5;
  localparam int POLARITY_BIT    = 7;
  localparam int PRECHARGE_BIT   = 4;
  localparam int IF_HALF_BIT     = 7;
  // Divider widths
  localparam int MAIN_REF_W = 13;
  localparam int MAIN_FB_W  = 19;
  localparam int AUX_REF_W  = 13;
  localparam int AUX_FB_W   = 14;
  // Bit rate generation
  localparam logic [7:0]  CLK_CTRL_RESET  = 8'h18;
  localparam logic [14:0] BIT_RATE_FACTOR = 15'h004b;
  localparam int          BIT_COUNT_W     = 15;
  // Host controller AXI4-Lite map
  localparam logic [7:0] HOST_CMD    = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam int         CMD_READ_BIT = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== shared/synth_reg_if.sv ====
/*
  Eight-bit register port between host controller and synthesiser block.
  Assumes both ends share the reference clock; strobes last one cycle.
*/
`timescale 1ns/1ps
interface synth_reg_if;
  logic       wr_strobe;
  logic       rd_strobe;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq;

  modport host_end (output wr_strobe, rd_strobe, addr, wdata, input rdata, irq);
  modport device_end (input wr_strobe, rd_strobe, addr, wdata, output rdata, irq);
endinterface

// ==== hdl/synth_device.sv ====
/*
  Synthesiser divider and bit rate clock control block.
  Assumes the register port is synchronous to clock, which is the
  reference clock, and lock detector inputs are asynchronous.
*/
// Chosen here: the eight-bit register port interface to the registers.
`timescale 1ns/1ps
module synth_device
  import synth_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  synth_reg_if.device_end            regs,
  input  wire logic                  main_lock_raw,
  input  wire logic                  aux_lock_raw,
  output logic                       main_enable,
  output logic                       aux_enable,
  output logic [MAIN_REF_W-1:0]      main_ref_div,
  output logic [MAIN_FB_W-1:0]       main_fb_div,
  output logic [AUX_REF_W-1:0]       aux_ref_div,
  output logic [AUX_FB_W-1:0]        aux_fb_div,
  output logic                       tx_lo_halving_select,
  output logic                       mixer_filter_high,
  output logic                       loop_polarity,
  output logic                       loop_precharge,
  output logic [1:0]                 if_filter_band,
  output logic                       if_path_halving,
  output logic                       main_locked,
  output logic                       aux_locked,
  output logic                       bit_tick
);

  typedef struct packed {
    logic [7:0]              main_ref_stage;
    logic [7:0]              main_top_stage;
    logic [7:0]              main_mid_stage;
    logic [7:0]              aux_ref_stage;
    logic [7:0]              aux_fb_stage;
    logic                    main_en;
    logic                    aux_en;
    logic [MAIN_REF_W-1:0]   main_ref;
    logic [MAIN_FB_W-1:0]    main_fb;
    logic [AUX_REF_W-1:0]    aux_ref;
    logic [AUX_FB_W-1:0]     aux_fb;
    logic                    lo_half;
    logic                    mix_high;
    logic                    polarity;
    logic                    precharge;
    logic [1:0]              if_band;
    logic                    if_half;
    logic [7:0]              clk_ctrl;
    logic [1:0]              lock_meta;
    logic [1:0]              lock_sync;
    logic [1:0]              lock_out;
    logic [1:0]              lock_lost;
    logic [1:0]              irq_en;
    logic [BIT_COUNT_W-1:0]  bit_count;
    logic                    tick;
    logic [7:0]              rdata;
    logic                    irq;
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;

  logic                   wr;
  logic                   rd;
  logic [1:0]             locked_now;
  logic [1:0]             lost_event;
  logic [BIT_COUNT_W-1:0] bit_limit;

  // Port decode
  assign wr = regs.wr_strobe;
  assign rd = regs.rd_strobe;

  // Lock qualified by enable after synchronising
  assign locked_now = state_reg.lock_sync & {state_reg.aux_en, state_reg.main_en};
  assign lost_event = state_reg.lock_out & ~locked_now;

  // Terminal count for 75*A*B reference cycles
  assign bit_limit = BIT_RATE_FACTOR * {11'h000, state_reg.clk_ctrl[7:4]}
                   * {11'h000, state_reg.clk_ctrl[3:0]} - 15'h0001;

  // Next-state logic
  always_comb begin
    state_next = state_reg;

    // Two-stage lock synchroniser
    state_next.lock_meta = {aux_lock_raw, main_lock_raw};
    state_next.lock_sync = state_reg.lock_meta;
    state_next.lock_out  = locked_now;

    // Main reference divider bytes
    if (wr && regs.addr == MAIN_REF_HI) begin
      state_next.main_ref_stage = regs.wdata;
      if (!regs.wdata[ENABLE_BIT]) begin
        state_next.main_en = 1'b0;
      end
    end
    if (wr && regs.addr == MAIN_REF_LO) begin
      state_next.main_ref = {state_reg.main_ref_stage[4:0], regs.wdata};
      state_next.lo_half  = state_reg.main_ref_stage[TX_LO_HALF_BIT];
      state_next.mix_high = state_reg.main_ref_stage[MIX_FILTER_BIT];
      state_next.main_en  = state_reg.main_ref_stage[ENABLE_BIT];
    end

    // Main feedback divider bytes
    if (wr && regs.addr == MAIN_FB_TOP) begin
      state_next.main_top_stage = regs.wdata;
    end
    if (wr && regs.addr == MAIN_FB_MID) begin
      state_next.main_mid_stage = regs.wdata;
    end
    if (wr && regs.addr == MAIN_FB_LO) begin
      state_next.main_fb   = {state_reg.main_top_stage[3:0], state_reg.main_mid_stage,
                              regs.wdata[6:0]};
      state_next.polarity  = state_reg.main_top_stage[POLARITY_BIT];
      state_next.precharge = state_reg.main_top_stage[PRECHARGE_BIT];
    end

    // Aux reference divider bytes
    if (wr && regs.addr == AUX_REF_HI) begin
      state_next.aux_ref_stage = regs.wdata;
      if (!regs.wdata[ENABLE_BIT]) begin
        state_next.aux_en = 1'b0;
      end
    end
    if (wr && regs.addr == AUX_REF_LO) begin
      state_next.aux_ref = {state_reg.aux_ref_stage[4:0], regs.wdata};
      state_next.if_band = state_reg.aux_ref_stage[6:5];
      state_next.aux_en  = state_reg.aux_ref_stage[ENABLE_BIT];
    end

    // Aux feedback divider bytes
    if (wr && regs.addr == AUX_FB_HI) begin
      state_next.aux_fb_stage = regs.wdata;
    end
    if (wr && regs.addr == AUX_FB_LO) begin
      state_next.aux_fb  = {state_reg.aux_fb_stage[5:0], regs.wdata};
      state_next.if_half = state_reg.aux_fb_stage[IF_HALF_BIT];
    end

    // Clock control and interrupt enables
    if (wr && regs.addr == BIT_RATE_CTRL) begin
      state_next.clk_ctrl = regs.wdata;
    end
    if (wr && regs.addr == LOCK_IRQ_EN) begin
      state_next.irq_en = regs.wdata[1:0];
    end

    // Quiescent dividers while in zero power
    if (!state_next.main_en) begin
      state_next.main_ref = '0;
      state_next.main_fb  = '0;
    end
    if (!state_next.aux_en) begin
      state_next.aux_ref = '0;
      state_next.aux_fb  = '0;
    end

    // Status read clears loss flags, new loss wins
    state_next.rdata = 8'h00;
    if (rd && regs.addr == LOCK_STATUS) begin
      state_next.rdata     = {4'h0, state_reg.lock_lost, locked_now};
      state_next.lock_lost = 2'b00;
    end
    state_next.lock_lost = state_next.lock_lost | lost_event;
    state_next.irq = |(state_next.lock_lost & state_next.irq_en);

    // Bit rate strobe
    state_next.tick = 1'b0;
    if (state_reg.bit_count >= bit_limit) begin
      state_next.bit_count = '0;
      state_next.tick      = 1'b1;
    end else begin
      state_next.bit_count = state_reg.bit_count + 15'h0001;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg          <= '0;
      state_reg.clk_ctrl <= CLK_CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state; synthesisers share this clock
  assign regs.rdata           = state_reg.rdata;
  assign regs.irq             = state_reg.irq;
  assign main_enable          = state_reg.main_en;
  assign aux_enable           = state_reg.aux_en;
  assign main_ref_div         = state_reg.main_ref;
  assign main_fb_div          = state_reg.main_fb;
  assign aux_ref_div          = state_reg.aux_ref;
  assign aux_fb_div           = state_reg.aux_fb;
  assign tx_lo_halving_select = state_reg.lo_half;
  assign mixer_filter_high    = state_reg.mix_high;
  assign loop_polarity        = state_reg.polarity;
  assign loop_precharge       = state_reg.precharge;
  assign if_filter_band       = state_reg.if_band;
  assign if_path_halving      = state_reg.if_half;
  assign main_locked          = state_reg.lock_out[0];
  assign aux_locked           = state_reg.lock_out[1];
  assign bit_tick             = state_reg.tick;

endmodule

// ==== hdl/synth_host.sv ====
/*
  Host controller: AXI4-Lite slave that turns command words into single
  cycles on the synthesiser register port and reports read data.
  Assumes the AXI master and the register port share clock.
*/
`timescale 1ns/1ps
module synth_host
  import synth_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  synth_reg_if.host_end    regs,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic [1:0]       s_bresp,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  wire logic [7:0]  s_araddr,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             host_irq
);

  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [7:0]  addr;
    logic [7:0]  pdata;
    logic        busy;
    logic [1:0]  phase;
    logic        is_read;
    logic [7:0]  last_read;
    logic        irq;
  } host_state_t;

  host_state_t state_reg;
  host_state_t state_next;

  // Next-state logic
  always_comb begin
    state_next           = state_reg;
    state_next.wr_strobe = 1'b0;
    state_next.rd_strobe = 1'b0;
    state_next.irq       = regs.irq;

    // Write address and data in either order
    if (s_awvalid && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_awaddr;
    end
    if (s_wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_wdata;
    end
    if (state_reg.bvalid && s_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Both halves held: act and respond
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = RESP_OKAY;
      if (state_reg.awaddr == HOST_CMD && !state_reg.busy) begin
        state_next.addr      = state_reg.wdata[15:8];
        state_next.pdata     = state_reg.wdata[7:0];
        state_next.is_read   = state_reg.wdata[CMD_READ_BIT];
        state_next.wr_strobe = !state_reg.wdata[CMD_READ_BIT];
        state_next.rd_strobe = state_reg.wdata[CMD_READ_BIT];
        state_next.busy      = 1'b1;
        state_next.phase     = 2'h0;
      end else begin
        state_next.bresp = RESP_SLVERR;
      end
    end

    // Port cycle: strobe, then device answers, then capture
    if (state_reg.busy) begin
      state_next.phase = state_reg.phase + 2'h1;
      if (state_reg.phase == 2'h1) begin
        state_next.busy = 1'b0;
        if (state_reg.is_read) begin
          state_next.last_read = regs.rdata;
        end
      end
    end

    // Read channel
    if (state_reg.rvalid && s_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      state_next.rdata  = 32'h0000_0000;
      if (s_araddr == HOST_STATUS) begin
        state_next.rdata = {16'h0000, state_reg.last_read, 6'h00,
                            state_reg.irq, state_reg.busy};
      end else if (s_araddr != HOST_CMD) begin
        state_next.rresp = RESP_SLVERR;
      end
    end

    // Readiness for the following cycle
    state_next.awready = !state_next.aw_got && !state_next.bvalid;
    state_next.wready  = !state_next.w_got && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
  end

  // State register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs from state
  assign regs.wr_strobe = state_reg.wr_strobe;
  assign regs.rd_strobe = state_reg.rd_strobe;
  assign regs.addr      = state_reg.addr;
  assign regs.wdata     = state_reg.pdata;
  assign s_awready      = state_reg.awready;
  assign s_wready       = state_reg.wready;
  assign s_bvalid       = state_reg.bvalid;
  assign s_bresp        = state_reg.bresp;
  assign s_arready      = state_reg.arready;
  assign s_rvalid       = state_reg.rvalid;
  assign s_rdata        = state_reg.rdata;
  assign s_rresp        = state_reg.rresp;
  assign host_irq       = state_reg.irq;

endmodule

// ==== sim/synth_port_sva.sv ====
/*
  Checker for the register port between host controller and synthesiser.
  Assumes plain hookup beside the interface, one clock, sync reset.
*/
`timescale 1ns/1ps
module synth_port_sva
  import synth_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire logic                  wr_strobe,
  input wire logic                  rd_strobe,
  input wire logic [7:0]            addr,
  input wire logic [7:0]            wdata,
  input wire logic [7:0]            rdata,
  input wire logic                  main_lock_raw,
  input wire logic                  aux_lock_raw,
  input wire logic                  main_enable,
  input wire logic                  aux_enable,
  input wire logic [MAIN_REF_W-1:0] main_ref_div,
  input wire logic [MAIN_FB_W-1:0]  main_fb_div,
  input wire logic [AUX_FB_W-1:0]   aux_fb_div,
  input wire logic                  main_locked,
  input wire logic                  aux_locked,
  input wire logic                  bit_tick
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Lock input steady long enough to cross the synchroniser
  sequence main_lock_held;
    (main_enable && main_lock_raw) [*3];
  endsequence
  sequence aux_lock_gone;
    (!aux_lock_raw) [*3];
  endsequence
  sequence status_read;
    rd_strobe && addr == LOCK_STATUS;
  endsequence

  lock_rise_a: assert property (main_lock_held |=> main_locked)
    else $error("main lock not shown three cycles after detector");
  lock_fall_a: assert property (aux_lock_gone |=> !aux_locked)
    else $error("aux lock shown while detector low");
  lock_enable_a: assert property (!main_enable |=> !main_locked)
    else $error("main lock shown while disabled");
  status_read_a: assert property (status_read |=> rdata[1:0] == {aux_locked, main_locked})
    else $error("status byte does not match lock outputs");
  rdata_idle_a: assert property (!(rd_strobe && addr == LOCK_STATUS) |=> rdata == 8'h00)
    else $error("read data not zero outside status read");
  zero_disabled_a: assert property (!main_enable |-> main_ref_div == '0
    && main_fb_div == '0)
    else $error("main dividers not quiescent while disabled");
  hi_clears_a: assert property (wr_strobe && addr == MAIN_REF_HI && !wdata[7]
    |=> !main_enable && main_ref_div == '0)
    else $error("high byte with enable low did not shut down");
  hi_stage_a: assert property (wr_strobe && addr == MAIN_REF_HI && wdata[7]
    |=> $stable(main_ref_div))
    else $error("high byte changed active divider");
  lo_load_a: assert property (wr_strobe && addr == MAIN_REF_LO |=> main_enable
    ? main_ref_div[7:0] == $past(wdata) : main_ref_div == '0)
    else $error("low byte did not load main reference divider");
  aux_load_a: assert property (wr_strobe && addr == AUX_FB_LO && aux_enable
    |=> aux_fb_div[7:0] == $past(wdata))
    else $error("low byte did not load aux feedback divider");
  tick_pulse_a: assert property (bit_tick |=> !bit_tick [*8])
    else $error("bit tick longer than one cycle or too close");
endmodule

// ==== sim/test_synth_divider_and_clock_control.sv ====
/*
  Testbench: host controller and synthesiser joined by the register port.
  Assumes AXI4-Lite stimulus on the host, lock detectors driven directly.
*/
`timescale 1ns/1ps
module test_synth_divider_and_clock_control
  import synth_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a0, d0, a1, d1, a2, d2;
    logic [8:0]  flags;
    logic [18:0] div;
  } row_t;
  logic                  clock, reset_n, main_lock_raw, aux_lock_raw;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, host_irq;
  logic [7:0]            awaddr, araddr, b;
  logic [31:0]           wdata, rdata, v;
  logic [1:0]            bresp, rresp, r;
  logic                  main_enable, aux_enable, tx_lo, mix_hi, pol, prech, if_half, tick;
  logic [1:0]            if_band;
  logic [MAIN_REF_W-1:0] main_ref_div;
  logic [MAIN_FB_W-1:0]  main_fb_div;
  logic [AUX_REF_W-1:0]  aux_ref_div;
  logic [AUX_FB_W-1:0]   aux_fb_div;
  logic                  main_locked, aux_locked;
  logic [8:0]            flag_vec;
  int                    errors, checked, cycles, g;
  row_t                  rows [11];

  assign flag_vec = {main_enable, aux_enable, tx_lo, mix_hi, pol, prech, if_band, if_half};

  synth_reg_if link ();
  synth_host synth_host_i (.clock(clock), .reset_n(reset_n), .regs(link.host_end),
    .s_awvalid(awvalid), .s_awready(awready), .s_awaddr(awaddr), .s_wvalid(wvalid),
    .s_wready(wready), .s_wdata(wdata), .s_wstrb(4'hf), .s_bvalid(bvalid),
    .s_bready(bready), .s_bresp(bresp), .s_arvalid(arvalid), .s_arready(arready),
    .s_araddr(araddr), .s_rvalid(rvalid), .s_rready(rready), .s_rdata(rdata),
    .s_rresp(rresp), .host_irq(host_irq));
  synth_device synth_device_i (.clock(clock), .reset_n(reset_n), .regs(link.device_end),
    .main_lock_raw(main_lock_raw), .aux_lock_raw(aux_lock_raw), .main_enable(main_enable),
    .aux_enable(aux_enable), .main_ref_div(main_ref_div), .main_fb_div(main_fb_div),
    .aux_ref_div(aux_ref_div), .aux_fb_div(aux_fb_div), .tx_lo_halving_select(tx_lo),
    .mixer_filter_high(mix_hi), .loop_polarity(pol), .loop_precharge(prech),
    .if_filter_band(if_band), .if_path_halving(if_half), .main_locked(main_locked),
    .aux_locked(aux_locked), .bit_tick(tick));
  synth_port_sva checker_i (.clock(clock), .reset_n(reset_n), .wr_strobe(link.wr_strobe),
    .rd_strobe(link.rd_strobe), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .main_lock_raw(main_lock_raw), .aux_lock_raw(aux_lock_raw), .main_enable(main_enable),
    .aux_enable(aux_enable), .main_ref_div(main_ref_div), .main_fb_div(main_fb_div),
    .aux_fb_div(aux_fb_div), .main_locked(main_locked), .aux_locked(aux_locked),
    .bit_tick(tick));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Watchdog on total run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // AXI write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Device cycle through the command word, then wait out the busy time
  task automatic dev_cmd(input logic rd, input logic [7:0] a, input logic [7:0] d);
    logic [1:0] rs;
    axi_write(HOST_CMD, {15'h0000, rd, a, d}, rs);
    check(rs, RESP_OKAY);
    repeat (3) @(posedge clock);
  endtask

  task automatic dev_read(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] st;
    logic [1:0]  rs;
    dev_cmd(1'b1, a, 8'h00);
    axi_read(HOST_STATUS, st, rs);
    d = st[15:8];
  endtask

  // Cycles between two bit ticks
  task automatic tick_gap(output int n);
    n = 0;
    @(posedge clock);
    while (tick !== 1'b1) @(posedge clock);
    do begin
      @(posedge clock);
      n++;
    end while (tick !== 1'b1);
  endtask

  function automatic logic [18:0] pick(input logic [7:0] a);
    case (a)
      MAIN_REF_LO: return 19'(main_ref_div);
      MAIN_FB_LO:  return 19'(main_fb_div);
      AUX_REF_LO:  return 19'(aux_ref_div);
      default:     return 19'(aux_fb_div);
    endcase
  endfunction

  initial begin
    rows = '{'{8'h21, 8'he3, 8'h21, 8'he3, 8'h20, 8'h45, 9'h160, 19'h00345},
             '{8'h21, 8'hc1, 8'h21, 8'hc1, 8'h20, 8'h02, 9'h140, 19'h00102},
             '{8'h21, 8'ha0, 8'h21, 8'ha0, 8'h20, 8'h10, 9'h120, 19'h00010},
             '{8'h24, 8'h95, 8'h23, 8'h12, 8'h22, 8'h83, 9'h138, 19'h28903},
             '{8'h24, 8'h03, 8'h23, 8'hff, 8'h22, 8'h7f, 9'h120, 19'h1ffff},
             '{8'h26, 8'h81, 8'h26, 8'h81, 8'h25, 8'h22, 9'h1a0, 19'h00122},
             '{8'h26, 8'ha0, 8'h26, 8'ha0, 8'h25, 8'h05, 9'h1a2, 19'h00005},
             '{8'h26, 8'hc3, 8'h26, 8'hc3, 8'h25, 8'h00, 9'h1a4, 19'h00300},
             '{8'h26, 8'hff, 8'h26, 8'hff, 8'h25, 8'hff, 9'h1a6, 19'h01fff},
             '{8'h28, 8'haa, 8'h28, 8'haa, 8'h27, 8'h0c, 9'h1a7, 19'h02a0c},
             '{8'h28, 8'h3f, 8'h28, 8'h3f, 8'h27, 8'h08, 9'h1a6, 19'h03f08}};
    {reset_n, main_lock_raw, aux_lock_raw, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check(flag_vec, 9'h000);
    check(main_ref_div, 13'h0000);
    tick_gap(g);
    check(g, 32'd600);
    // Ordinary programming cases
    foreach (rows[i]) begin
      dev_cmd(1'b0, rows[i].a0, rows[i].d0);
      dev_cmd(1'b0, rows[i].a1, rows[i].d1);
      dev_cmd(1'b0, rows[i].a2, rows[i].d2);
      check(flag_vec, rows[i].flags);
      check(pick(rows[i].a2), rows[i].div);
    end
    // High byte alone is only staged
    dev_cmd(1'b0, MAIN_REF_HI, 8'hff);
    check(main_ref_div, 13'h0010);
    check(tx_lo, 1'b0);
    dev_cmd(1'b0, MAIN_REF_LO, 8'h00);
    check(main_ref_div, 13'h1f00);
    check(tx_lo, 1'b1);
    // Lock, status, loss interrupt and masking
    main_lock_raw <= 1'b1;
    aux_lock_raw <= 1'b1;
    repeat (5) @(posedge clock);
    check({main_locked, aux_locked}, 2'b11);
    dev_read(LOCK_STATUS, b);
    check(b, 8'h03);
    dev_cmd(1'b0, LOCK_IRQ_EN, 8'h01);
    main_lock_raw <= 1'b0;
    repeat (5) @(posedge clock);
    check({main_locked, host_irq}, 2'b01);
    axi_read(HOST_STATUS, v, r);
    check(v[1], 1'b1);
    dev_read(LOCK_STATUS, b);
    check(b, 8'h06);
    check(host_irq, 1'b0);
    aux_lock_raw <= 1'b0;
    repeat (5) @(posedge clock);
    check(host_irq, 1'b0);
    dev_read(LOCK_STATUS, b);
    check(b, 8'h08);
    // Shutdown by high byte alone while locked
    main_lock_raw <= 1'b1;
    repeat (5) @(posedge clock);
    dev_cmd(1'b0, MAIN_REF_HI, 8'h7f);
    check({main_enable, main_locked}, 2'b00);
    check({main_ref_div, main_fb_div}, 32'h0);
    // New bit rate dividers, B=3 A=15: base near 2.67MHz, about 11.9kb/s
    dev_cmd(1'b0, BIT_RATE_CTRL, 8'h3f);
    tick_gap(g);
    check(g, 32'd3375);
    // Mid-run reset restores defaults
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check({flag_vec, main_locked}, 10'h000);
    tick_gap(g);
    check(g, 32'd600);
    // Host map refusals, and zero read of the command word
    axi_write(8'h08, 32'h0, r);
    check(r, RESP_SLVERR);
    axi_read(8'h0c, v, r);
    check(v, 32'h0);
    check(r, RESP_SLVERR);
    axi_read(HOST_CMD, v, r);
    check(v, 32'h0);
    check(r, RESP_OKAY);
    print_verdict();
  end
endmodule
